// >>> alarm_pkg.sv
package alarm_pkg;
  // alarm register bit positions
  localparam int BIT_PWF = 0;
  localparam int BIT_STALL = 1;
  localparam int BIT_LOCK = 2;
  localparam int BIT_PARITY = 3;
  localparam int BIT_TEMP = 4;
  localparam int BIT_HDW = 5;
  localparam int BIT_IO = 6;
  localparam int BIT_PROGRAMMABLE_ALARM = 7;
  // command bits that clear a latched alarm
  localparam logic [7:0] CMD_CLEAR_MASK = 8'hCB;
  localparam int CMD_RESTART_BIT = 1;
  // relay drivers that are off while their alarm is active
  localparam logic [7:0] RELAY_INVERT_MASK = 8'h07;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  // stall period limits and clock
  localparam int STALL_MIN_S = 1;
  localparam int STALL_MAX_S = 5;
  localparam int CLK_HZ = 10000000;
  localparam logic [25:0] STALL_MIN_CYC = 26'(STALL_MIN_S * CLK_HZ);
  localparam logic [25:0] STALL_MAX_CYC = 26'(STALL_MAX_S * CLK_HZ);

  // bus function strobes presented by the processor
  typedef struct packed {
    logic cmd;
    logic wdata;
    logic sense;
    logic rdata;
    logic ack;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] alarm;
    logic [25:0] timer;
    logic expired;
    logic irq;
    logic [7:0] dout;
    logic dvalid;
    logic [7:0] lamp;
    logic [7:0] relay;
    logic ack_out;
  } alarm_state_t;
endpackage

// >>> system_alarm_monitor.sv
// Overview of operation
// - power failure or any system initialize sets the power-fail bit
// - stall timer expiry sets stall bit and the interrupt queue flop
// - core parity error input sets the parity bit
// - overtemperature sensor input sets the temperature bit
// - write data with bit 6 set sets the I/O alarm
// - write data with bit 7 set sets the programmable alarm
// - every alarm except lockout and bit 5 latches its own bit and lights its lamp; lockout follows stall disable
// - command with bit 1 set restarts the stall timer
// - stall period configurable between one and five seconds
// - interrupt acknowledge clears queue flop and stall bit, no restart
// - stall disable holds timer and queue flop reset, sets lockout bit
// - bit 5 is set while power, stall, lockout or parity bit is set
// - selects add temp, I/O, programmable to hardware lamp/relay only
// - command bits 0,1,3,6,7 clear their latched alarms
// - sense status and read data both return the alarm register
// - each alarm bit drives its own relay driver output
// - relays 0..2 off when alarm active, 3..7 on when active
`timescale 1ns/1ps
module system_alarm_monitor
  import alarm_pkg::*;
#(
  parameter logic [25:0] STALL_PERIOD = STALL_MIN_CYC
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire bus_req_t bus_req,
  input wire logic [7:0] bus_din,
  input wire logic power_fail,
  input wire logic sys_init,
  input wire logic parity_error,
  input wire logic over_temp,
  input wire logic stall_disable,
  input wire logic [2:0] hdw_select,
  output logic [7:0] bus_dout,
  output logic bus_dvalid,
  output logic int_request,
  output logic int_ack_done,
  output logic [7:0] lamp,
  output logic [7:0] relay
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  alarm_state_t s_q, s_d;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [7:0] relay_of(input logic [7:0] a);
    relay_of = a ^ RELAY_INVERT_MASK;
  endfunction

  logic [7:0] clr;
  logic [7:0] set;
  logic restart;
  logic hit;
  logic [7:0] alarm_n;
  logic [7:0] show;

  always_comb
  begin
    s_d = s_q;
    clr = bus_req.cmd ? (bus_din & CMD_CLEAR_MASK) : 8'h00;
    restart = bus_req.cmd && bus_din[CMD_RESTART_BIT];
    hit = 1'b0;
    // stall timer: restart wins over counting; expiry is held
    if (stall_disable)
    begin
      s_d.timer = 26'h0;
      s_d.expired = 1'b0;
    end
    else if (restart)
    begin
      s_d.timer = 26'h0;
      s_d.expired = 1'b0;
    end
    else if (!s_q.expired)
    begin
      if (s_q.timer + 26'h1 >= STALL_PERIOD)
      begin
        s_d.expired = 1'b1;
        hit = 1'b1;
      end
      else
        s_d.timer = s_q.timer + 26'h1;
    end
    set = 8'h00;
    set[BIT_PWF] = power_fail | sys_init;
    set[BIT_STALL] = hit;
    set[BIT_PARITY] = parity_error;
    set[BIT_TEMP] = over_temp;
    set[BIT_IO] = bus_req.wdata && bus_din[BIT_IO];
    set[BIT_PROGRAMMABLE_ALARM] = bus_req.wdata && bus_din[BIT_PROGRAMMABLE_ALARM];
    // set wins over a same-cycle clear
    alarm_n = (s_q.alarm & ~clr) | set;
    if (bus_req.ack)
      alarm_n[BIT_STALL] = set[BIT_STALL];
    alarm_n[BIT_LOCK] = stall_disable;
    alarm_n[BIT_HDW] = alarm_n[BIT_PWF] | alarm_n[BIT_STALL]
                     | alarm_n[BIT_LOCK] | alarm_n[BIT_PARITY];
    s_d.alarm = alarm_n;
    if (stall_disable)
      s_d.irq = 1'b0;
    else if (hit)
      s_d.irq = 1'b1;
    else if (bus_req.ack)
      s_d.irq = 1'b0;
    s_d.ack_out = bus_req.ack && s_q.irq;
    s_d.dvalid = bus_req.sense | bus_req.rdata;
    s_d.dout = s_d.dvalid ? s_q.alarm : 8'h00;
    show = alarm_n;
    show[BIT_HDW] = alarm_n[BIT_HDW]
                  | (hdw_select[0] & alarm_n[BIT_TEMP])
                  | (hdw_select[1] & alarm_n[BIT_IO])
                  | (hdw_select[2] & alarm_n[BIT_PROGRAMMABLE_ALARM]);
    s_d.lamp = show;
    s_d.relay = relay_of(show);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.alarm <= ALARM_RESET;
      s_q.relay <= RELAY_INVERT_MASK;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  assign bus_dout = s_q.dout;
  assign bus_dvalid = s_q.dvalid;
  assign int_request = s_q.irq;
  assign int_ack_done = s_q.ack_out;
  assign lamp = s_q.lamp;
  assign relay = s_q.relay;

  // checks
  stall_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && hit && !stall_disable |=> s_q.alarm[BIT_STALL] && s_q.irq)
    else $error("stall expiry lost");
  pwf_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sys_init |=> s_q.alarm[BIT_PWF])
    else $error("power fail bit not set");
  parity_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && parity_error |=> s_q.alarm[BIT_PARITY])
    else $error("parity bit not set");
  temp_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && over_temp |=> s_q.alarm[BIT_TEMP])
    else $error("temperature bit not set");
  io_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.wdata && bus_din[6] |=> s_q.alarm[BIT_IO])
    else $error("io alarm not set");
  programmable_alarm_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.wdata && bus_din[7] |=> s_q.alarm[BIT_PROGRAMMABLE_ALARM])
    else $error("programmable alarm not set");
  lockout_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && stall_disable |=> !s_q.irq && s_q.alarm[BIT_LOCK]
      && s_q.timer == 26'h0)
    else $error("lockout not held");
  ack_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.ack && !hit |=> !s_q.irq && !s_q.alarm[BIT_STALL])
    else $error("acknowledge did not clear");
  restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && restart && !stall_disable |=> s_q.timer == 26'h0
      && !s_q.expired)
    else $error("restart ignored");
  hdw_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.alarm[BIT_HDW] == (s_q.alarm[0] | s_q.alarm[1] | s_q.alarm[2]
      | s_q.alarm[3]))
    else $error("hardware bit wrong");
  relay_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> relay == (lamp ^ RELAY_INVERT_MASK))
    else $error("relay polarity wrong");
  read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && (bus_req.sense || bus_req.rdata) |=> bus_dvalid
      && bus_dout == $past(s_q.alarm))
    else $error("status byte wrong");
  clear_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.cmd && bus_din[3] && !parity_error
      |=> !s_q.alarm[BIT_PARITY])
    else $error("clear ignored");

  pwf_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && power_fail
    |=> s_q.alarm[BIT_PWF])
    else $error("power fail input lost");
  pwf_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_q.alarm[BIT_PWF] && !(bus_req.cmd && bus_din[BIT_PWF])
    |=> s_q.alarm[BIT_PWF])
    else $error("power fail bit dropped");
  parity_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_q.alarm[BIT_PARITY] && !(bus_req.cmd && bus_din[BIT_PARITY])
    |=> s_q.alarm[BIT_PARITY])
    else $error("parity bit dropped");
  temp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_q.alarm[BIT_TEMP]
    |=> s_q.alarm[BIT_TEMP])
    else $error("temperature bit dropped");
  io_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_q.alarm[BIT_IO] && !(bus_req.cmd && bus_din[BIT_IO])
    |=> s_q.alarm[BIT_IO])
    else $error("io alarm dropped");
  programmable_alarm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_q.alarm[BIT_PROGRAMMABLE_ALARM] && !(bus_req.cmd && bus_din[BIT_PROGRAMMABLE_ALARM])
    |=> s_q.alarm[BIT_PROGRAMMABLE_ALARM])
    else $error("programmable alarm dropped");
  io_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.cmd && bus_din[BIT_IO] && !bus_req.wdata
    |=> !s_q.alarm[BIT_IO])
    else $error("io clear ignored");
  programmable_alarm_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.cmd && bus_din[BIT_PROGRAMMABLE_ALARM] && !bus_req.wdata
    |=> !s_q.alarm[BIT_PROGRAMMABLE_ALARM])
    else $error("programmable clear ignored");
  pwf_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.cmd && bus_din[BIT_PWF] && !power_fail && !sys_init
    |=> !s_q.alarm[BIT_PWF])
    else $error("power fail clear ignored");
  stall_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.cmd && bus_din[BIT_STALL]
    |=> !s_q.alarm[BIT_STALL])
    else $error("stall clear ignored");
  lock_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !stall_disable
    |=> !s_q.alarm[BIT_LOCK])
    else $error("lockout bit stuck");
  lock_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && stall_disable
    |=> !s_q.expired)
    else $error("timer ran in lockout");
  lamp_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    {lamp[7:6], lamp[4:0]}
      == {s_q.alarm[7:6], s_q.alarm[4:0]})
    else $error("lamp differs from alarm");
  lamp_hdw_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.alarm[BIT_HDW]
    |-> lamp[BIT_HDW])
    else $error("hardware lamp dark");
  sel_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && hdw_select == 3'b000
    |=> lamp[BIT_HDW] == s_q.alarm[BIT_HDW])
    else $error("hardware lamp without select");
  dout_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !bus_req.sense && !bus_req.rdata
    |=> !bus_dvalid && bus_dout == 8'h00)
    else $error("data without request");
  ack_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.ack && s_q.irq
    |=> int_ack_done)
    else $error("acknowledge not answered");
  ack_none_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !bus_req.ack
    |=> !int_ack_done)
    else $error("answer without acknowledge");
  irq_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_q.irq && !bus_req.ack && !stall_disable
    |=> s_q.irq)
    else $error("interrupt request dropped");
  irq_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !s_q.irq && !hit
    |=> !s_q.irq)
    else $error("interrupt without expiry");
  ack_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && bus_req.ack && s_q.expired && !restart && !stall_disable
    |=> s_q.expired)
    else $error("acknowledge restarted timer");
  expired_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && s_q.expired && !restart && !stall_disable
    |=> s_q.expired)
    else $error("expiry not held");
  timer_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !stall_disable && !restart && !s_q.expired && !hit
    |=> s_q.timer == $past(s_q.timer) + 26'h1)
    else $error("timer did not count");
  timer_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.timer
      < STALL_PERIOD)
    else $error("timer beyond period");
  freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en
    |=> $stable(s_q))
    else $error("state moved while disabled");

  wr_cov: cover property (@(posedge clk) disable iff (!rst_n)
    bus_req.wdata && bus_din[BIT_PROGRAMMABLE_ALARM]);
  stall_cov: cover property (@(posedge clk) disable iff (!rst_n) hit);
  ack_cov: cover property (@(posedge clk) disable iff (!rst_n)
    s_q.irq && bus_req.ack);
  lock_cov: cover property (@(posedge clk) disable iff (!rst_n)
    stall_disable && s_q.irq);
  sel_cov: cover property (@(posedge clk) disable iff (!rst_n)
    hdw_select[0] && over_temp);
endmodule

// >>> cpu_int_model.sv
`timescale 1ns/1ps
module cpu_int_model (
  input wire logic clk,
  input wire logic auto_ack,
  input wire logic int_request,
  output logic ack
);
  // one acknowledge cycle per queued request; the gap avoids a double ack
  initial ack = 1'b0;
  always @(posedge clk)
  begin
    ack <= auto_ack & int_request & ~ack;
  end
endmodule

// >>> system_alarm_monitor_tb_top.sv
`timescale 1ns/1ps
module system_alarm_monitor_tb_top;
  import alarm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] req_v = 4'h0;
  logic [3:0] ev = 4'h0;
  logic [7:0] din = 8'h00;
  logic [7:0] base = 8'h24;
  logic stall_disable = 1'b1;
  logic [2:0] hdw_select = 3'b000;
  logic auto_ack = 1'b0;
  logic ack;
  logic [7:0] bus_dout, lamp, relay;
  logic bus_dvalid, int_request, int_ack_done;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  logic [7:0] ev_exp[3] = '{8'h21, 8'h21, 8'h28};
  logic [7:0] ev_clr[3] = '{8'h01, 8'h01, 8'h08};
  always #50 clk = ~clk;
  cpu_int_model i_cpu (.clk(clk), .auto_ack(auto_ack),
    .int_request(int_request), .ack(ack));
  system_alarm_monitor #(.STALL_PERIOD(26'd20)) i_dut (.clk(clk),
    .nrst(nrst), .clk_en(1'b1), .bus_req(bus_req_t'({req_v, ack})),
    .bus_din(din), .power_fail(ev[0]), .sys_init(ev[1]),
    .parity_error(ev[2]), .over_temp(ev[3]),
    .stall_disable(stall_disable), .hdw_select(hdw_select),
    .bus_dout(bus_dout), .bus_dvalid(bus_dvalid),
    .int_request(int_request), .int_ack_done(int_ack_done),
    .lamp(lamp), .relay(relay));
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // f: 3 command, 2 write data, 1 sense status, 0 read data
  task put(input int f, input logic [7:0] d);
    @(posedge clk);
    req_v[f] <= 1'b1;
    din <= d;
    @(posedge clk);
    req_v[f] <= 1'b0;
  endtask
  task rd(input int f, input logic [7:0] e);
    put(f, 8'h00);
    #1;
    chk({7'h00, bus_dvalid}, 8'h01);
    chk(bus_dout, e | base);
    chk(relay, (e | base | ((hdw_select[0] && e[4]) ? 8'h20 : 8'h00))
      ^ 8'h07);
  endtask
  task pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task wait_hi(input int which);
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk);
      #1;
      if ((which == 0 ? int_request : int_ack_done) === 1'b1)
        break;
    end
    if (n == 60)
    begin
      n_mismatch++;
      $display("Error at %0t: wait ran out", $time);
      give_verdict;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // lockout held so the short stall period cannot fire meanwhile
    put(3, 8'hFF);
    rd(1, 8'h00);
    chk(lamp, 8'h24);
    for (int i = 0; i < 3; i++)
    begin
      pulse(i);
      rd(i % 2, ev_exp[i]);
      put(3, ev_clr[i]);
      rd(1, 8'h00);
    end
    put(2, 8'hC0);
    rd(0, 8'hC0);
    put(3, 8'h40);
    rd(1, 8'h80);
    put(3, 8'h80);
    rd(1, 8'h00);
    $display("alarm set and clear test done");
    stall_disable <= 1'b0;
    base <= 8'h00;
    put(3, 8'h02);
    rd(1, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      repeat (10) @(posedge clk);
      put(3, 8'h02);
    end
    chk({7'h00, int_request}, 8'h00);
    wait_hi(0);
    chk({7'h00, n >= 16 && n <= 22}, 8'h01);
    rd(1, 8'h22);
    auto_ack <= 1'b1;
    wait_hi(1);
    auto_ack <= 1'b0;
    rd(1, 8'h00);
    repeat (30) @(posedge clk);
    chk({7'h00, int_request}, 8'h00);
    $display("stall test done");
    hdw_select <= 3'b001;
    pulse(3);
    rd(1, 8'h10);
    chk(lamp, 8'h30);
    put(3, 8'hFF);
    rd(1, 8'h10);
    $display("temperature test done");
    give_verdict;
  end
endmodule
